// File: sdl_loader.sv
`timescale 1ns/1ps
`include "sdl_regs.svh"

// Functional notes
// - Words arrive MSB first and each data bit is taken on the serial clock rising edge.
// - An 8-clock transfer lands in the configuration word when select is released.
// - A 16-clock transfer lands in the reference divider word, its low 13 bits in the holding stage.
// - A 24-clock transfer lands in the loop divider word.
// - All programmable registers stay still while bits shift and change only on select release.
// - The low 13 reference bits have a holding stage and a separate active stage.
// - The upper 3 reference bits take effect at once when a 16-clock transfer ends.
// - Loading the loop divider word also copies the reference holding stage to the active stage.
// - A select pulse with no clock edges copies the holding stage to the active stage only.
// - The target register follows from transfer length alone, in any order.
// - The select rising edge commits the shifted word according to the clock count.
// - With select high, clock edges are ignored and the port stays initialised.
// - In cascade mode the shift register MSB is driven out on the clock falling edge.
module sdl_loader
	import sdl_pkg::*;
(
	// Clock and reset
	input  wire logic                        ref_clk,
	input  wire logic                        nrst,
	// Serial programming pins
	input  wire logic                        ser_clk,
	input  wire logic                        ser_din,
	input  wire logic                        port_select_n,
	// Cascade data out
	output logic                             cascade_dout_r,
	// Programmed registers
	output logic [`SDL_CFG_W-1:0]            config_word_r,
	output logic [`SDL_REF_LO_W-1:0]         ref_hold_r,
	output logic [`SDL_REF_LO_W-1:0]         ref_active_r,
	output logic [`SDL_REF_HI_W-1:0]         ref_mode_r,
	output logic [`SDL_LOOP_W-1:0]           loop_divider_word_r
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic                    sclk_s1;
	logic                    sclk_s2;
	logic                    sclk_s3;
	logic                    din_s1;
	logic                    din_s2;
	logic                    din_s3;
	logic                    sel_s1;
	logic                    sel_s2;

	// Limitation: each serial clock phase must last three system clocks,
	// or two edges fold into one and a bit is lost from the count.
	// Data takes the same path one stage deeper, so the bit taken at a
	// rising edge is the one that stood on the pin before that edge.
	// Two stages before use, a third for edge detection
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_s3 <= 1'b0;
			din_s1  <= 1'b0;
			din_s2  <= 1'b0;
			din_s3  <= 1'b0;
			sel_s1  <= 1'b1;
			sel_s2  <= 1'b1;
		end else begin
			sclk_s1 <= ser_clk;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			din_s1  <= ser_din;
			din_s2  <= din_s1;
			din_s3  <= din_s2;
			sel_s1  <= port_select_n;
			sel_s2  <= sel_s1;
		end
	end

	// ****************************************************************
	// Decode
	// ****************************************************************
	sdl_port_t               state_r;
	sdl_port_t               state_nxt;
	logic [`SDL_SHIFT_W-1:0] shift_r;
	logic [`SDL_CNT_W-1:0]   cnt_r;
	wire                     sclk_rise;
	wire                     sclk_fall;
	wire                     shifting;
	wire                     commit;
	wire                     cmt_cfg;
	wire                     cmt_ref;
	wire                     cmt_loop;
	wire                     cmt_copy;
	wire                     dout_mode;
	wire                     copy_active;

	// Edges seen on the synchronised clock
	assign sclk_rise = sclk_s2 & ~sclk_s3;
	assign sclk_fall = ~sclk_s2 & sclk_s3;
	// Select released cleanly, with the clock low
	assign shifting  = (state_r == sdl_shift) & ~sel_s2;
	assign commit    = (state_r == sdl_shift) & sel_s2 & ~sclk_s2;
	// Length alone picks the target; odd lengths commit nothing
	assign cmt_cfg   = commit & (cnt_r == `SDL_CNT_CFG);
	assign cmt_ref   = commit & (cnt_r == `SDL_CNT_REF);
	assign cmt_loop  = commit & (cnt_r == `SDL_CNT_LOOP);
	assign cmt_copy  = commit & (cnt_r == `SDL_CNT_NONE);
	assign dout_mode = loop_divider_word_r[`SDL_OUTA_MSB:`SDL_OUTA_LSB] == `SDL_OUTA_DOUT;
	// Both loop loads and bare pulses refresh the active stage
	assign copy_active = cmt_loop | cmt_copy;

	// ****************************************************************
	// Port sequencer
	// ****************************************************************
	// Select moving while the clock is high drops sync until both rest
	// A lost transfer commits nothing, not even the active-stage copy,
	// and the port stays deaf until select is high with the clock low.
	// Trade-off: a glitchy select costs one transfer, never a bad word.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			sdl_idle: begin
				if (!sel_s2) begin
					state_nxt = sclk_s2 ? sdl_lost : sdl_shift;
				end
			end
			sdl_shift: begin
				if (sel_s2) begin
					state_nxt = sclk_s2 ? sdl_lost : sdl_idle;
				end
			end
			sdl_lost: begin
				if (sel_s2 && !sclk_s2) begin
					state_nxt = sdl_idle;
				end
			end
			default: begin
				state_nxt = sdl_idle;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state_r <= sdl_idle;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ****************************************************************
	// Shift register and clock counter
	// ****************************************************************
	// MSB-first capture
	always_ff @(posedge ref_clk) begin
		if (!nrst || state_r != sdl_shift) begin
			shift_r <= `SDL_SHIFT_RST;
			cnt_r   <= `SDL_CNT_NONE;
		end else if (shifting && sclk_rise) begin
			shift_r <= {shift_r[`SDL_SHIFT_W-2:0], din_s3};
			cnt_r   <= (cnt_r == `SDL_CNT_MAX) ? cnt_r : cnt_r + 6'h01;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			cascade_dout_r <= 1'b0;
		end else if (dout_mode && shifting && sclk_fall) begin
			cascade_dout_r <= shift_r[`SDL_SHIFT_W-1];
		end
	end

	// ****************************************************************
	// Programmable registers
	// ****************************************************************
	// Commit on release only
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			config_word_r       <= `SDL_CFG_RST;
			ref_hold_r          <= `SDL_REF_LO_RST;
			ref_mode_r          <= `SDL_REF_HI_RST;
			loop_divider_word_r <= `SDL_LOOP_RST;
		end else begin
			if (cmt_cfg) begin
				config_word_r <= shift_r[`SDL_CFG_W-1:0];
			end
			if (cmt_ref) begin
				ref_hold_r <= shift_r[`SDL_REF_LO_W-1:0];
				ref_mode_r <= shift_r[`SDL_REF_HI_MSB:`SDL_REF_HI_LSB];
			end
			if (cmt_loop) begin
				loop_divider_word_r <= shift_r;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			ref_active_r <= `SDL_REF_LO_RST;
		end else if (copy_active) begin
			ref_active_r <= ref_hold_r;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	cfg_load_a: assert property (
		cmt_cfg |=> config_word_r == $past(shift_r[7:0]))
		else $error("config word not loaded from 8-clock transfer");

	ref_hold_load_a: assert property (
		cmt_ref |=> ref_hold_r == $past(shift_r[12:0]) && ref_active_r == $past(ref_active_r))
		else $error("reference holding stage load wrong");

	loop_load_a: assert property (
		cmt_loop |=> loop_divider_word_r == $past(shift_r))
		else $error("loop divider word not loaded");

	hold_still_a: assert property (
		!commit |=> $stable(config_word_r) && $stable(loop_divider_word_r)
			&& $stable(ref_hold_r) && $stable(ref_mode_r))
		else $error("register changed without select release");

	ref_mode_now_a: assert property (
		cmt_ref |=> ref_mode_r == $past(shift_r[15:13]))
		else $error("upper reference bits not immediate");

	loop_copy_a: assert property (
		cmt_loop |=> ref_active_r == $past(ref_hold_r))
		else $error("active stage not copied on loop load");

	bare_pulse_a: assert property (
		cmt_copy |=> ref_active_r == $past(ref_hold_r) && $stable(config_word_r)
			&& $stable(loop_divider_word_r))
		else $error("bare select pulse mishandled");

	msb_first_a: assert property (
		shifting && sclk_rise && cnt_r != `SDL_CNT_MAX
		|=> shift_r[0] == $past(din_s3) && shift_r[23:1] == $past(shift_r[22:0]))
		else $error("bit not shifted in MSB first");

	idle_clear_a: assert property (
		sel_s2 && state_r == sdl_idle ##1 sel_s2 |-> cnt_r == `SDL_CNT_NONE)
		else $error("port not initialised while deselected");

	dout_edge_a: assert property (
		dout_mode && shifting && sclk_fall |=> cascade_dout_r == $past(shift_r[23]))
		else $error("cascade bit not driven on falling edge");

	// Neighbouring registers and port state, one clock after the event;
	// these catch a commit that spills into a register it does not own.
	active_still_a: assert property (
		!copy_active |=> $stable(ref_active_r))
		else $error("active stage moved without a copy");

	cfg_only_a: assert property (
		cmt_cfg |=> $stable(ref_hold_r) && $stable(ref_active_r)
			&& $stable(ref_mode_r) && $stable(loop_divider_word_r))
		else $error("8-clock transfer touched another register");

	ref_only_a: assert property (
		cmt_ref |=> $stable(config_word_r) && $stable(loop_divider_word_r))
		else $error("16-clock transfer touched another register");

	loop_only_a: assert property (
		cmt_loop |=> $stable(config_word_r) && $stable(ref_hold_r)
			&& $stable(ref_mode_r))
		else $error("24-clock transfer touched reference or config bits");

	bare_keep_a: assert property (
		cmt_copy |=> $stable(ref_hold_r) && $stable(ref_mode_r))
		else $error("bare select pulse changed the holding stage");

	port_init_a: assert property (
		state_r != sdl_shift |=> shift_r == `SDL_SHIFT_RST && cnt_r == `SDL_CNT_NONE)
		else $error("serial port not held initialised");

	dout_still_a: assert property (
		!(dout_mode && shifting && sclk_fall) |=> $stable(cascade_dout_r))
		else $error("cascade bit moved off a falling edge");

	count_step_a: assert property (
		shifting && sclk_rise && cnt_r != `SDL_CNT_MAX |=> cnt_r == $past(cnt_r) + 6'h01)
		else $error("clock count not advanced by one");

	rise_only_a: assert property (
		shifting && !sclk_rise |=> $stable(shift_r) && $stable(cnt_r))
		else $error("shift register moved without a rising edge");

	commit_idle_a: assert property (
		commit |=> state_r == sdl_idle)
		else $error("port did not return to idle after commit");

	select_idle_a: assert property (
		state_r == sdl_idle && sel_s2 |=> state_r == sdl_idle)
		else $error("port left idle while deselected");

endmodule

// File: sdl_regs.svh
`ifndef SDL_REGS_SVH
`define SDL_REGS_SVH

// ****************************************************************
// Field widths and positions
// ****************************************************************
`define SDL_CFG_W        8
`define SDL_REF_LO_W     13
`define SDL_REF_HI_W     3
`define SDL_REF_HI_MSB   15
`define SDL_REF_HI_LSB   13
`define SDL_LOOP_W       24
`define SDL_SHIFT_W      24
`define SDL_CNT_W        6
`define SDL_OUTA_MSB     23
`define SDL_OUTA_LSB     22

// ****************************************************************
// Transfer lengths and codes
// ****************************************************************
`define SDL_CNT_NONE     6'h00
`define SDL_CNT_CFG      6'h08
`define SDL_CNT_REF      6'h10
`define SDL_CNT_LOOP     6'h18
`define SDL_CNT_MAX      6'h3F
`define SDL_OUTA_DOUT    2'h1

// ****************************************************************
// Reset values
// ****************************************************************
`define SDL_CFG_RST      8'h00
`define SDL_REF_LO_RST   13'h0000
`define SDL_REF_HI_RST   3'h0
`define SDL_LOOP_RST     24'h400000
`define SDL_SHIFT_RST    24'h000000

`endif

// File: sdl_pkg.sv
package sdl_pkg;

	// Serial port sequencing states
	typedef enum logic [1:0] {
		sdl_idle  = 2'b00,
		sdl_shift = 2'b01,
		sdl_lost  = 2'b10
	} sdl_port_t;

endpackage

// File: sdl_mcu_model.sv
`timescale 1ns/1ps

// ****************************************************************
// Controller model driving the serial programming pins
// ****************************************************************
module sdl_mcu_model (
	// System clock
	input  wire logic ref_clk,
	// Serial pins
	output logic      ser_clk,
	output logic      ser_din,
	output logic      port_select_n
);
	// Idle pins: select high, clock low
	initial begin
		ser_clk = 1'b0;
		ser_din = 1'b0;
		port_select_n = 1'b1;
	end

	// Wait n system clocks
	task automatic hold(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// MSB first, legal lengths, select moved with clock low
	task automatic send(input logic [23:0] data, input int n, input logic sel);
		@(posedge ref_clk);
		port_select_n <= ~sel;
		hold(4);
		for (int i = n - 1; i >= 0; i--) begin
			ser_din <= data[i];
			hold(4);
			ser_clk <= 1'b1;
			hold(4);
			ser_clk <= 1'b0;
			ser_din <= ~data[i]; // Past hold time, so no stale value
			hold(4);
		end
		port_select_n <= 1'b1;
		hold(10); // Covers commit latency and select-high gap
	endtask
endmodule

// File: tb.sv
`timescale 1ns/1ps

// ****************************************************************
// Testbench for the serial register loader
// ****************************************************************
module tb;
	logic        ref_clk;
	logic        nrst;
	logic        ser_clk;
	logic        ser_din;
	logic        port_select_n;
	logic        cascade_dout_r;
	logic [7:0]  config_word_r;
	logic [12:0] ref_hold_r;
	logic [12:0] ref_active_r;
	logic [2:0]  ref_mode_r;
	logic [23:0] loop_divider_word_r;
	int          fails;
	int          n_checks;

	sdl_loader u_sdl_loader (.ref_clk(ref_clk), .nrst(nrst), .ser_clk(ser_clk),
		.ser_din(ser_din), .port_select_n(port_select_n), .cascade_dout_r(cascade_dout_r),
		.config_word_r(config_word_r), .ref_hold_r(ref_hold_r), .ref_active_r(ref_active_r),
		.ref_mode_r(ref_mode_r), .loop_divider_word_r(loop_divider_word_r));

	sdl_mcu_model u_sdl_mcu_model (.ref_clk(ref_clk), .ser_clk(ser_clk), .ser_din(ser_din),
		.port_select_n(port_select_n));

	// 100 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Single value compare
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// All programmed registers at once
	task automatic chk_regs(input logic [7:0] c, input logic [12:0] h, input logic [12:0] a,
		input logic [2:0] m, input logic [23:0] l);
		chk(24'(config_word_r), 24'(c));
		chk(24'(ref_hold_r), 24'(h));
		chk(24'(ref_active_r), 24'(a));
		chk(24'(ref_mode_r), 24'(m));
		chk(loop_divider_word_r, l);
	endtask

	// Verdict and end of run
	task automatic close_out;
		$display("Checks %0d, errors %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Watchdog, far beyond the roughly 1300 cycles needed
	initial begin
		repeat (20000) @(posedge ref_clk);
		fails++;
		close_out();
	end

	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial begin
		fails = 0;
		n_checks = 0;
		nrst = 1'b0;
		repeat (20) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		u_sdl_mcu_model.send(24'hFFFFFF, 24, 1'b0);
		chk_regs(8'h00, 13'h0000, 13'h0000, 3'h0, 24'h400000);
		chk(24'(cascade_dout_r), 24'h0);
		u_sdl_mcu_model.send(24'h0000A5, 8, 1'b1);
		chk_regs(8'hA5, 13'h0000, 13'h0000, 3'h0, 24'h400000);
		u_sdl_mcu_model.send(24'h00B123, 16, 1'b1);
		chk_regs(8'hA5, 13'h1123, 13'h0000, 3'h5, 24'h400000);
		// Small counts keep the main count above the swallow count
		u_sdl_mcu_model.send(24'h8ABCDE, 24, 1'b1);
		chk_regs(8'hA5, 13'h1123, 13'h1123, 3'h5, 24'h8ABCDE);
		chk(24'(cascade_dout_r), 24'h1);
		u_sdl_mcu_model.send(24'h000042, 16, 1'b1);
		chk_regs(8'hA5, 13'h0042, 13'h1123, 3'h0, 24'h8ABCDE);
		u_sdl_mcu_model.send(24'h000000, 0, 1'b1);
		chk_regs(8'hA5, 13'h0042, 13'h0042, 3'h0, 24'h8ABCDE);
		// Registers must hold while a new word is still shifting
		fork
			u_sdl_mcu_model.send(24'h00003C, 8, 1'b1);
			begin
				repeat (40) @(posedge ref_clk);
				chk(24'(config_word_r), 24'hA5);
			end
		join
		chk_regs(8'h3C, 13'h0042, 13'h0042, 3'h0, 24'h8ABCDE);
		close_out();
	end
endmodule
